// [core/deser_cfg_pkg.sv]
// constants, field layout and reset values of the deserializer configuration bank
// assumes a single 250 MHz clock domain and an asynchronous active-high reset
//
// Operation
// [RQ1] config bit 4 picks output strobe edge
// [RQ2] mode field 00/01 normal, filter off/on
// [RQ3] mode field 10/11 selects older-link compatibility
// [RQ4] sleep bit keeps registers, not power-down
// [RQ5] bit 0: pins or registers, address excluded
// [RQ6] address bit 7 picks pin or register
// [RQ7] seven-bit address field, reset 1110000
// [RQ8] hold bit 0 forces outputs low
// [RQ9] hold-low acts only while locked
// [RQ10] sleep state 0: outputs low, pass high
// [RQ11] sleep state 1: outputs released, pass high
// [RQ12] map field sets compat-mode LSB mapping
// [RQ13] override bit disables strap-driven hold-low
// [RQ14] oscillator select field, 000 disables
// [RQ15] defaults at reset, writes apply next access
// [RQ16] host writes only permitted addresses; the bank stores any written value and only flags it on bus_address_valid
package deser_cfg_pkg;

  // ==========================================================
  // register offsets and reset values
  localparam logic [7:0] OFS_CONFIG_ONE = 8'h00;
  localparam logic [7:0] OFS_BUS_ADDR = 8'h01;
  localparam logic [7:0] OFS_FEATURES = 8'h02;
  localparam logic [7:0] RST_CONFIG_ONE = 8'h00;
  localparam logic [7:0] RST_BUS_ADDR = 8'h70;
  localparam logic [7:0] RST_FEATURES = 8'h00;
  localparam logic [7:0] UNMAPPED_READ = 8'h00;

  // ==========================================================
  // field positions
  localparam int STROBE_EDGE_BIT = 4;
  localparam int MODE_HI = 3;
  localparam int MODE_LO = 2;
  localparam int SLEEP_BIT = 1;
  localparam int REG_CTRL_BIT = 0;
  localparam int ADDR_SRC_BIT = 7;
  localparam int ADDR_HI = 6;
  localparam int HOLD_LOW_BIT = 7;
  localparam int SLEEP_STATE_BIT = 6;
  localparam int MAP_HI = 5;
  localparam int MAP_LO = 4;
  localparam int STRAP_OVR_BIT = 3;
  localparam int OSC_HI = 2;

  // ==========================================================
  // encodings
  typedef enum logic [1:0] {
    MODE_NORMAL = 2'h0,
    MODE_NORMAL_FILTER = 2'h1,
    MODE_COMPAT_NEWER = 2'h2,
    MODE_COMPAT_OLDER = 2'h3
  } link_mode_t;

  localparam logic [1:0] MAP_PAIR = 2'h0;
  localparam logic [1:0] MAP_ANY = 2'h1;
  localparam logic [2:0] OSC_OFF = 3'h0;

  localparam logic [6:0] ADDR_OK_A = 7'h71;
  localparam logic [6:0] ADDR_OK_B = 7'h72;
  localparam logic [6:0] ADDR_OK_C = 7'h73;
  localparam logic [6:0] ADDR_OK_D = 7'h76;

  localparam int DATA_W = 24;
  localparam int CTRL_W = 3;
  localparam logic [3:0] BYTE_BITS = 4'h8;

  typedef enum logic [2:0] {
    BUS_IDLE = 3'b000,
    BUS_ADDR = 3'b001,
    BUS_ADDR_ACK = 3'b010,
    BUS_WRITE = 3'b011,
    BUS_WRITE_ACK = 3'b100,
    BUS_READ = 3'b101,
    BUS_READ_ACK = 3'b110
  } bus_state_t;

endpackage

// [core/pin_history.sv]
// one serial-bus line: registered level plus rise and fall pulses
// assumes the line is already synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module pin_history (
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic line_in,
  output logic level,
  output logic rise,
  output logic fall
);
  logic prev_reg;

  // ==========================================================
  // history
  // idle bus lines sit high, so reset to high avoids a false edge
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      level <= 1'b1;
      prev_reg <= 1'b1;
    end else begin
      level <= line_in;
      prev_reg <= level;
    end
  end

  assign rise = level & ~prev_reg;
  assign fall = ~level & prev_reg;
endmodule
`default_nettype wire

// [core/output_stage.sv]
// parallel output path: hold-low, sleep state and compat LSB mapping
// assumes data, control, lock and pass arrive synchronous to sys_clk
`timescale 1ns/10ps
`default_nettype none
module output_stage
  import deser_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [CTRL_W-1:0] ctrl_in,
  input wire logic rec_clk_in,
  input wire logic lock_in,
  input wire logic pass_in,
  input wire logic edge_rising,
  input wire logic compat,
  input wire logic [1:0] map_sel,
  input wire logic force_low,
  input wire logic sleep,
  input wire logic sleep_release,
  output logic [DATA_W-1:0] data_out,
  output logic [CTRL_W-1:0] ctrl_out,
  output logic clk_out,
  output logic out_oe,
  output logic lock_out,
  output logic pass_out
);
  logic [DATA_W-1:0] mapped;
  logic any_one;

  // ==========================================================
  // compat LSB mapping
  // the older links carry two fewer data bits; the low pair is refilled here
  assign any_one = |data_in;
  always_comb begin
    mapped = data_in;
    if (compat) begin
      // [RQ12] compat LSB fill
      case (map_sel)
        MAP_PAIR: mapped[1:0] = data_in[5:4];
        MAP_ANY: mapped[1:0] = {2{any_one}};
        default: mapped[1:0] = 2'h0;
      endcase
    end
  end

  // ==========================================================
  // output registers
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      data_out <= '0;
      ctrl_out <= '0;
      clk_out <= 1'b0;
      out_oe <= 1'b1;
    end else if (sleep) begin
      // [RQ10] [RQ11] sleep output state
      data_out <= '0;
      ctrl_out <= '0;
      clk_out <= 1'b0;
      out_oe <= ~sleep_release;
    end else if (force_low) begin
      // [RQ8] hold outputs low
      data_out <= '0;
      ctrl_out <= '0;
      clk_out <= 1'b0;
      out_oe <= 1'b1;
    end else begin
      // [RQ1] strobe edge choice
      data_out <= mapped;
      ctrl_out <= ctrl_in;
      clk_out <= edge_rising ? rec_clk_in : ~rec_clk_in;
      out_oe <= 1'b1;
    end
  end

  // lock is never gated; pass reads high during sleep
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      lock_out <= 1'b0;
      pass_out <= 1'b0;
    end else begin
      lock_out <= lock_in;
      pass_out <= pass_in | sleep;
    end
  end
endmodule
`default_nettype wire

// [core/deser_config_bank.sv]
// deserializer configuration bank with its two-wire serial control bus slave
// assumes scl/sda already synchronous to sys_clk; sda is open drain outside
`timescale 1ns/10ps
`default_nettype none
module deser_config_bank
  import deser_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic scl_in,
  input wire logic sda_in,
  output logic sda_out,
  output logic sda_oe,
  input wire logic [6:0] addr_pin_value,
  input wire logic strobe_edge_pin,
  input wire logic [1:0] mode_pin,
  input wire logic hold_low_strap,
  input wire logic lock_in,
  input wire logic pass_in,
  input wire logic rec_clk_in,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [CTRL_W-1:0] ctrl_in,
  output logic recovered_clock_output,
  output logic [DATA_W-1:0] data_out,
  output logic control_output_one,
  output logic control_output_two,
  output logic control_output_three,
  output logic out_oe,
  output logic lock_out,
  output logic pass_out,
  output logic output_strobe_edge_select,
  output logic [1:0] link_mode,
  output logic ctrl_filter_en,
  output logic compat_mode,
  output logic sleep_active,
  output logic [2:0] internal_oscillator_select,
  output logic internal_osc_en,
  output logic [6:0] active_bus_address,
  output logic bus_address_valid
);
  // ==========================================================
  // declarations
  logic [7:0] config_one_reg;
  logic [7:0] bus_addr_reg;
  logic [7:0] features_reg;
  bus_state_t state_reg;
  logic [3:0] bit_cnt_reg;
  logic [7:0] shift_reg;
  logic [7:0] ptr_reg;
  logic is_read_reg;
  logic first_byte_reg;
  logic ack_ok_reg;
  logic scl_level, scl_rise, scl_fall;
  logic sda_level, sda_rise, sda_fall;
  logic start_seen, stop_seen;
  logic byte_in_done, wr_en, rd_load;
  logic [7:0] rd_data;
  logic reg_ctrl, hold_feature_on, force_low;
  logic [CTRL_W-1:0] ctrl_out_bus;
  link_mode_t mode_eff;

  // ==========================================================
  // bus line history
  pin_history u_scl (
    .sys_clk(sys_clk),
    .rst(rst),
    .line_in(scl_in),
    .level(scl_level),
    .rise(scl_rise),
    .fall(scl_fall)
  );

  pin_history u_sda (
    .sys_clk(sys_clk),
    .rst(rst),
    .line_in(sda_in),
    .level(sda_level),
    .rise(sda_rise),
    .fall(sda_fall)
  );

  assign start_seen = sda_fall & scl_level;
  assign stop_seen = sda_rise & scl_level;

  // open drain: only ever pull low
  assign sda_out = 1'b0;

  // ==========================================================
  // address select
  // [RQ6] address source select
  assign active_bus_address = bus_addr_reg[ADDR_SRC_BIT] ? bus_addr_reg[ADDR_HI:0] : addr_pin_value;

  // [RQ16] permitted address check
  assign bus_address_valid = (bus_addr_reg[ADDR_HI:0] == ADDR_OK_A) ||
                             (bus_addr_reg[ADDR_HI:0] == ADDR_OK_B) ||
                             (bus_addr_reg[ADDR_HI:0] == ADDR_OK_C) ||
                             (bus_addr_reg[ADDR_HI:0] == ADDR_OK_D);

  // ==========================================================
  // transfer strobes
  assign byte_in_done = (state_reg == BUS_WRITE) && scl_fall && (bit_cnt_reg == BYTE_BITS);
  assign wr_en = byte_in_done && !first_byte_reg;
  assign rd_load = scl_fall && (((state_reg == BUS_ADDR_ACK) && is_read_reg) ||
                                ((state_reg == BUS_READ_ACK) && ack_ok_reg));

  always_comb begin
    case (ptr_reg)
      OFS_CONFIG_ONE: rd_data = config_one_reg;
      OFS_BUS_ADDR: rd_data = bus_addr_reg;
      OFS_FEATURES: rd_data = features_reg;
      default: rd_data = UNMAPPED_READ;
    endcase
  end

  // ==========================================================
  // serial bus slave state machine
  // start and stop win over any bit activity in the same cycle
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      state_reg <= BUS_IDLE;
      bit_cnt_reg <= 4'h0;
      shift_reg <= 8'h00;
      is_read_reg <= 1'b0;
      ack_ok_reg <= 1'b0;
      sda_oe <= 1'b0;
    end else if (start_seen) begin
      state_reg <= BUS_ADDR;
      bit_cnt_reg <= 4'h0;
      sda_oe <= 1'b0;
    end else if (stop_seen) begin
      state_reg <= BUS_IDLE;
      sda_oe <= 1'b0;
    end else begin
      case (state_reg)
        BUS_ADDR, BUS_WRITE: begin
          if (scl_rise && (bit_cnt_reg != BYTE_BITS)) begin
            shift_reg <= {shift_reg[6:0], sda_level};
            bit_cnt_reg <= bit_cnt_reg + 4'h1;
          end else if (scl_fall && (bit_cnt_reg == BYTE_BITS)) begin
            bit_cnt_reg <= 4'h0;
            if (state_reg == BUS_WRITE) begin
              state_reg <= BUS_WRITE_ACK;
              sda_oe <= 1'b1;
            end else if (shift_reg[7:1] == active_bus_address) begin
              state_reg <= BUS_ADDR_ACK;
              is_read_reg <= shift_reg[0];
              sda_oe <= 1'b1;
            end else begin
              // not ours: stay off the bus until the next start
              state_reg <= BUS_IDLE;
            end
          end
        end
        BUS_ADDR_ACK, BUS_WRITE_ACK: begin
          if (scl_fall) begin
            if (rd_load) begin
              state_reg <= BUS_READ;
              shift_reg <= rd_data;
              sda_oe <= ~rd_data[7];
              bit_cnt_reg <= 4'h1;
            end else begin
              state_reg <= BUS_WRITE;
              sda_oe <= 1'b0;
            end
          end
        end
        BUS_READ: begin
          if (scl_fall) begin
            if (bit_cnt_reg == BYTE_BITS) begin
              state_reg <= BUS_READ_ACK;
              sda_oe <= 1'b0;
            end else begin
              sda_oe <= ~shift_reg[6];
              shift_reg <= {shift_reg[6:0], 1'b0};
              bit_cnt_reg <= bit_cnt_reg + 4'h1;
            end
          end
        end
        BUS_READ_ACK: begin
          if (scl_rise) begin
            ack_ok_reg <= ~sda_level;
          end else if (scl_fall) begin
            if (rd_load) begin
              state_reg <= BUS_READ;
              shift_reg <= rd_data;
              sda_oe <= ~rd_data[7];
              bit_cnt_reg <= 4'h1;
            end else begin
              // host refused the byte: read ends here
              state_reg <= BUS_IDLE;
            end
          end
        end
        default: begin
          state_reg <= BUS_IDLE;
          sda_oe <= 1'b0;
        end
      endcase
    end
  end

  // ==========================================================
  // register pointer
  // first written byte is the pointer; data then auto-increments
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      first_byte_reg <= 1'b1;
    end else if (start_seen) begin
      first_byte_reg <= 1'b1;
    end else if (byte_in_done) begin
      first_byte_reg <= 1'b0;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      ptr_reg <= 8'h00;
    end else if (byte_in_done && first_byte_reg) begin
      ptr_reg <= shift_reg;
    end else if (wr_en || rd_load) begin
      ptr_reg <= ptr_reg + 8'h01;
    end
  end

  // ==========================================================
  // registers
  // [RQ15] defaults and bus writes
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      config_one_reg <= RST_CONFIG_ONE;
    end else if (wr_en && (ptr_reg == OFS_CONFIG_ONE)) begin
      config_one_reg <= shift_reg;
    end
  end

  // [RQ16] host picks a permitted address
  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      bus_addr_reg <= RST_BUS_ADDR;
    end else if (wr_en && (ptr_reg == OFS_BUS_ADDR)) begin
      bus_addr_reg <= shift_reg;
    end
  end

  always_ff @(posedge sys_clk or posedge rst) begin
    if (rst) begin
      features_reg <= RST_FEATURES;
    end else if (wr_en && (ptr_reg == OFS_FEATURES)) begin
      features_reg <= shift_reg;
    end
  end

  // ==========================================================
  // effective configuration
  // [RQ5] pin or register control
  assign reg_ctrl = config_one_reg[REG_CTRL_BIT];
  assign output_strobe_edge_select = reg_ctrl ? config_one_reg[STROBE_EDGE_BIT] : strobe_edge_pin;
  assign mode_eff = link_mode_t'(reg_ctrl ? config_one_reg[MODE_HI:MODE_LO] : mode_pin);
  assign link_mode = mode_eff;

  // [RQ2] normal mode filter
  assign ctrl_filter_en = (mode_eff == MODE_NORMAL_FILTER);

  // [RQ3] compatibility modes
  assign compat_mode = (mode_eff == MODE_COMPAT_NEWER) || (mode_eff == MODE_COMPAT_OLDER);

  // [RQ4] sleep, registers kept
  assign sleep_active = config_one_reg[SLEEP_BIT];

  // [RQ13] strap override
  assign hold_feature_on = hold_low_strap && !features_reg[STRAP_OVR_BIT];

  // [RQ9] hold only while locked
  assign force_low = hold_feature_on && lock_in && !features_reg[HOLD_LOW_BIT];

  // [RQ14] oscillator select
  assign internal_oscillator_select = features_reg[OSC_HI:0];
  assign internal_osc_en = (features_reg[OSC_HI:0] != OSC_OFF);

  // ==========================================================
  // output path
  output_stage u_out (
    .sys_clk(sys_clk),
    .rst(rst),
    .data_in(data_in),
    .ctrl_in(ctrl_in),
    .rec_clk_in(rec_clk_in),
    .lock_in(lock_in),
    .pass_in(pass_in),
    .edge_rising(output_strobe_edge_select),
    .compat(compat_mode),
    .map_sel(features_reg[MAP_HI:MAP_LO]),
    .force_low(force_low),
    .sleep(sleep_active),
    .sleep_release(features_reg[SLEEP_STATE_BIT]),
    .data_out(data_out),
    .ctrl_out(ctrl_out_bus),
    .clk_out(recovered_clock_output),
    .out_oe(out_oe),
    .lock_out(lock_out),
    .pass_out(pass_out)
  );

  assign control_output_one = ctrl_out_bus[0];
  assign control_output_two = ctrl_out_bus[1];
  assign control_output_three = ctrl_out_bus[2];
endmodule
`default_nettype wire

// [tb/deser_config_bank_assertions.sv]
// checker for the configuration bank's output path and derived settings
// assumes binding to deser_config_bank; sees only its ports
`timescale 1ns/10ps
`default_nettype none
module deser_config_bank_assertions
  import deser_cfg_pkg::*;
(
  input wire logic sys_clk,
  input wire logic rst,
  input wire logic lock_in,
  input wire logic pass_in,
  input wire logic rec_clk_in,
  input wire logic hold_low_strap,
  input wire logic [DATA_W-1:0] data_in,
  input wire logic [DATA_W-1:0] data_out,
  input wire logic recovered_clock_output,
  input wire logic control_output_one,
  input wire logic control_output_two,
  input wire logic control_output_three,
  input wire logic out_oe,
  input wire logic lock_out,
  input wire logic pass_out,
  input wire logic output_strobe_edge_select,
  input wire logic [1:0] link_mode,
  input wire logic ctrl_filter_en,
  input wire logic compat_mode,
  input wire logic sleep_active,
  input wire logic [2:0] internal_oscillator_select,
  input wire logic internal_osc_en
);
  default clocking cb @(posedge sys_clk);
  endclocking
  default disable iff (rst);

  // ==========================================================
  // helper sequences
  // hold-low can only act while locked and strapped, so outside that the path is plain
  sequence normal_s;
    !$past(rst) && !$past(sleep_active) && !($past(lock_in) && $past(hold_low_strap));
  endsequence
  sequence sleeping_s;
    !$past(rst) && $past(sleep_active);
  endsequence

  // ==========================================================
  // checks
  a_filter_mode: assert property (ctrl_filter_en == (link_mode == 2'h1))
    else $error("filter enable disagrees with link mode");
  a_compat_mode: assert property (compat_mode == link_mode[1])
    else $error("compat flag disagrees with link mode");
  a_osc_enable: assert property (internal_osc_en == (internal_oscillator_select != 3'h0))
    else $error("oscillator enable disagrees with select");
  a_lock_follows: assert property (!$past(rst) |-> lock_out == $past(lock_in))
    else $error("lock output not following lock input");
  a_awake_pass: assert property (!$past(rst) && !$past(sleep_active) |-> pass_out == $past(pass_in))
    else $error("pass output wrong while awake");
  a_sleep_pass: assert property (sleeping_s |-> pass_out)
    else $error("pass output low during sleep");
  a_sleep_quiet: assert property (sleeping_s |-> data_out == '0 && !recovered_clock_output
    && !control_output_one && !control_output_two && !control_output_three)
    else $error("outputs not low during sleep");
  a_oe_sleep_only: assert property (!out_oe |-> $past(sleep_active))
    else $error("outputs released outside sleep");
  a_unlocked_data: assert property (normal_s |-> data_out[DATA_W-1:2] == $past(data_in[DATA_W-1:2]))
    else $error("data not passed through on the plain path");
  a_clock_edge: assert property (normal_s |-> recovered_clock_output ==
    ($past(output_strobe_edge_select) ? $past(rec_clk_in) : !$past(rec_clk_in)))
    else $error("recovered clock polarity wrong");
endmodule
`default_nettype wire

// [tb/serial_host_model.sv]
// two-wire bus host: drives scl and an open-drain pull on sda
// assumes the bench resolves sda_line from all pulls with a pull-up
`timescale 1ns/10ps
`default_nettype none
module serial_host_model (
  input wire logic sys_clk,
  input wire logic sda_line,
  output logic scl,
  output logic sda_pull
);
  initial begin
    scl = 1'b1;
    sda_pull = 1'b0;
  end

  // ==========================================================
  // bus phases
  // four cycles a phase, one above the slave's minimum of three
  task automatic wait_cyc(input int n);
    repeat (n) @(posedge sys_clk);
    #1;
  endtask
  task automatic start_c();
    sda_pull = 1'b1;
    wait_cyc(4);
  endtask
  // sda changes one cycle after scl falls, never while scl is high
  task automatic bit_io(input logic b, output logic r);
    scl = 1'b0;
    wait_cyc(1);
    sda_pull = ~b;
    wait_cyc(3);
    scl = 1'b1;
    wait_cyc(4);
    r = sda_line;
  endtask
  // p=1 gives a stop, p=0 a repeated start
  task automatic frame(input logic p);
    scl = 1'b0;
    wait_cyc(1);
    sda_pull = p;
    wait_cyc(3);
    scl = 1'b1;
    wait_cyc(4);
    sda_pull = ~p;
    wait_cyc(4);
  endtask
endmodule
`default_nettype wire

// [tb/deser_config_bank_tb_top.sv]
// testbench: register access over the two-wire bus and output path checks
// assumes serial_host_model as bus host and the checker bound below
`timescale 1ns/10ps
`default_nettype none
module deser_config_bank_tb_top
  import deser_cfg_pkg::*;
;
  logic sys_clk, rst, scl, sda_pull, sda_oe, strobe_edge_pin, hold_low_strap, lock_in, pass_in;
  logic rec_clk_in = 1'b0;
  logic recovered_clock_output, control_output_one, control_output_two, control_output_three, out_oe;
  logic lock_out, pass_out, output_strobe_edge_select, ctrl_filter_en, compat_mode, sleep_active;
  logic internal_osc_en, bus_address_valid, ack_bit;
  logic [6:0] addr_pin_value, active_bus_address;
  logic [1:0] mode_pin, link_mode;
  logic [2:0] internal_oscillator_select;
  logic [DATA_W-1:0] data_in, data_out;
  logic [CTRL_W-1:0] ctrl_in;
  logic [7:0] rd;
  wire logic sda_line;
  int n_mismatch = 0;
  int check_count = 0;
  assign sda_line = ~(sda_pull | sda_oe);

  deser_config_bank dut_u (.sda_out(), .scl_in(scl), .sda_in(sda_line), .*);
  serial_host_model host_u (.sys_clk(sys_clk), .sda_line(sda_line), .scl(scl), .sda_pull(sda_pull));

  initial begin
    sys_clk = 1'b0;
    forever #2 sys_clk = ~sys_clk;
  end
  always @(posedge sys_clk) rec_clk_in <= #1 ~rec_clk_in;

  // ==========================================================
  // tasks
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    check_count++;
    if (g !== e) begin
      n_mismatch++;
      $display("wrong value %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic send(input logic [7:0] b, output logic ack);
    logic r;
    for (int i = 7; i >= 0; i--) host_u.bit_io(b[i], r);
    host_u.bit_io(1'b1, r);
    ack = ~r;
  endtask
  task automatic put(input logic [6:0] a, input logic [7:0] p, input logic [7:0] d);
    logic k;
    host_u.start_c();
    send({a, 1'b0}, k);
    chk("address ack", 24'h1, k);
    send(p, k);
    send(d, k);
    chk("data ack", 24'h1, k);
    host_u.frame(1'b1);
    host_u.wait_cyc(2);
  endtask
  task automatic get(input logic [6:0] a, input logic [7:0] p, output logic [7:0] d);
    logic k, r;
    host_u.start_c();
    send({a, 1'b0}, k);
    send(p, k);
    host_u.frame(1'b0);
    send({a, 1'b1}, k);
    chk("read ack", 24'h1, k);
    for (int i = 7; i >= 0; i--) begin
      host_u.bit_io(1'b1, r);
      d[i] = r;
    end
    // a released ack slot ends the read
    host_u.bit_io(1'b1, r);
    host_u.frame(1'b1);
  endtask
  task automatic close_out();
    $display("mismatches %0d of %0d checks", n_mismatch, check_count);
    if (n_mismatch == 0 && check_count > 0) $display("No errors found");
    else $display("Errors were found");
    $finish;
  endtask

  // ==========================================================
  // sequence of tests
  initial begin
    #200000;
    n_mismatch++;
    close_out();
  end
  initial begin
    logic [7:0] rst_tab [3];
    rst_tab = '{8'h00, 8'h70, 8'h00};
    rst = 1'b1;
    addr_pin_value = 7'h71;
    strobe_edge_pin = 1'b1;
    mode_pin = 2'h1;
    hold_low_strap = 1'b0;
    lock_in = 1'b1;
    pass_in = 1'b0;
    data_in = 24'hA5C330;
    ctrl_in = 3'h5;
    repeat (16) @(posedge sys_clk);
    #1 rst = 1'b0;
    host_u.wait_cyc(3);
    for (int i = 0; i < 3; i++) begin
      get(7'h71, i[7:0], rd);
      chk("reset value", {16'h0, rst_tab[i]}, rd);
    end
    get(7'h71, 8'h07, rd);
    chk("unmapped read", 24'h0, rd);
    chk("pin address", 24'h71, active_bus_address);
    chk("pin mode", 24'h1, link_mode);
    chk("pin edge", 24'h1, output_strobe_edge_select);
    mode_pin = 2'h2;
    strobe_edge_pin = 1'b0;
    host_u.wait_cyc(1);
    chk("pin compat", 24'h1, compat_mode);
    chk("pin edge low", 24'h0, output_strobe_edge_select);
    // pin says rising from here, so register-driven falling is visible
    strobe_edge_pin = 1'b1;
    for (int m = 0; m < 4; m++) begin
      put(7'h71, 8'h00, {4'h0, m[1:0], 2'b01});
      chk("mode", m, link_mode);
      chk("filter", m == 1, ctrl_filter_en);
      chk("compat", m[1], compat_mode);
      chk("falling edge", 24'h0, output_strobe_edge_select);
    end
    // still in the oldest compat mode: map field shapes the two low bits
    // bits 5:4 = 01 so pair copy, any-one fill and zero all differ
    data_in = 24'hA5C310;
    for (int k = 0; k < 8; k++) begin
      put(7'h71, 8'h02, {2'b10, k[1:0], 1'b0, k[2:0]});
      get(7'h71, 8'h02, rd);
      chk("features readback", {2'b10, k[1:0], 1'b0, k[2:0]}, rd);
      chk("oscillator", k, internal_oscillator_select);
      chk("oscillator on", k != 0, internal_osc_en);
      chk("mapped lsb", k[1:0] == 0 ? data_in[5:4] : k[1:0] == 1 ? {2{|data_in}} : 2'b00, data_out[1:0]);
      chk("upper data", data_in[23:2], data_out[23:2]);
    end
    put(7'h71, 8'h00, 8'h11);
    chk("rising edge", 24'h1, output_strobe_edge_select);
    hold_low_strap = 1'b1;
    put(7'h71, 8'h02, 8'h00);
    chk("held low", 24'h0, data_out);
    chk("held ctrl", 24'h0, {control_output_three, control_output_two, control_output_one});
    chk("lock kept", 24'h1, lock_out);
    lock_in = 1'b0;
    host_u.wait_cyc(2);
    chk("unlocked data", data_in, data_out);
    lock_in = 1'b1;
    put(7'h71, 8'h02, 8'h08);
    chk("strap override", data_in, data_out);
    put(7'h71, 8'h02, 8'h80);
    chk("released", data_in, data_out);
    put(7'h71, 8'h00, 8'h13);
    chk("sleep flag", 24'h1, sleep_active);
    chk("sleep data low", 24'h0, data_out);
    chk("sleep ctrl low", 24'h0, {control_output_three, control_output_two, control_output_one});
    chk("sleep driven", 24'h1, out_oe);
    chk("sleep pass", 24'h1, pass_out);
    put(7'h71, 8'h02, 8'hC0);
    chk("sleep released", 24'h0, out_oe);
    chk("sleep pass high", 24'h1, pass_out);
    get(7'h71, 8'h00, rd);
    chk("config kept", 24'h13, rd);
    put(7'h71, 8'h00, 8'h11);
    chk("awake driven", 24'h1, out_oe);
    chk("awake data", data_in, data_out);
    chk("awake pass", 24'h0, pass_out);
    chk("ctrl through", 24'h5, {control_output_three, control_output_two, control_output_one});
    ctrl_in = 3'h2;
    pass_in = 1'b1;
    host_u.wait_cyc(2);
    chk("ctrl follows", 24'h2, {control_output_three, control_output_two, control_output_one});
    chk("pass follows", 24'h1, pass_out);
    pass_in = 1'b0;
    put(7'h71, 8'h01, 8'hF6);
    chk("register address", 24'h76, active_bus_address);
    chk("address valid", 24'h1, bus_address_valid);
    get(7'h76, 8'h01, rd);
    chk("address readback", 24'hF6, rd);
    host_u.start_c();
    send({7'h71, 1'b0}, ack_bit);
    chk("old address refused", 24'h0, ack_bit);
    host_u.frame(1'b1);
    close_out();
  end
endmodule
bind deser_config_bank deser_config_bank_assertions chk_u (.*);
`default_nettype wire
